// *** verilog/idp_port.sv ***
// sixteen-line industrial input port with hysteresis, debounce and readback
//
// How it works
// - level above rise threshold sets state one
// - level below fall threshold sets state zero
// - between thresholds the previous state holds
// - accept new state after stable_time_ms unchanged
// - zero stable time bypasses the debouncer
// - stable time clamps to 327 ms
// - thresholds and stable time kept per line
// - whole-port read gives sixteen debounced bits
// - per-line read gives state in bit 0
// - every read samples all sixteen lines
// - driven lines read back the written value
// - drive enables are sixteen-bit mask, lsb line 0
//
// Level codes come from an on-chip converter sequencer that runs on the
// same clock, one line per strobe, so they are taken without synchronisers.
`timescale 1ns/1ps
module idp_port
  import idp_pkg::*;
#(
  // cycles per millisecond tick; shorten in simulation
  parameter int TICK_CYCLES = idp_pkg::MS_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // per-line configuration write
  input wire logic cfg_we,
  input wire logic [idp_pkg::LINE_W-1:0] cfg_line,
  input wire idp_pkg::idp_level_t cfg_fall,
  input wire idp_pkg::idp_level_t cfg_rise,
  input wire logic [idp_pkg::REQ_MS_W-1:0] cfg_stable_ms,
  // measured levels from the converter sequencer
  input wire logic sample_valid,
  input wire logic [idp_pkg::LINE_W-1:0] sample_line,
  input wire idp_pkg::idp_level_t sample_level,
  // shared output side of the port lines
  input wire idp_pkg::idp_word_t out_en_mask,
  input wire idp_pkg::idp_word_t out_data,
  // read request
  input wire logic read_req,
  input wire logic read_view,
  input wire logic [idp_pkg::LINE_W-1:0] read_line,
  // read answer
  output logic read_valid,
  output logic [idp_pkg::LINES-1:0] read_data,
  // live status
  output idp_pkg::idp_word_t line_state,
  output idp_pkg::idp_word_t detect_state
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [REQ_MS_W-1:0] REQ_MAX = REQ_MS_W'(STABLE_MAX_MS);

  logic [TICK_W-1:0] tick_cnt;
  logic ms_tick;
  idp_word_t snapshot;

  wire tick_wrap;
  wire [TICK_W-1:0] next_tick_cnt;
  wire clamp_hit;
  wire [MS_W-1:0] stable_clamped;
  wire [LINES-1:0] cfg_load;
  wire [LINES-1:0] sample_hit;
  wire [LINES-1:0] detected;
  wire [LINES-1:0] debounced;
  wire [LINES-1:0] view_word;
  wire view_bit;
  wire [LINES-1:0] next_read_data;

  // free-running millisecond timebase shared by all debouncers
  assign tick_wrap = tick_cnt == TICK_LAST;
  assign next_tick_cnt = tick_wrap ? '0 : tick_cnt + TICK_W'(1);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      ms_tick <= tick_wrap;
    end
  end

  // longer requests are cut to the limit rather than wrapped
  assign clamp_hit = cfg_stable_ms > REQ_MAX;
  assign stable_clamped = clamp_hit ? STABLE_MAX_MS : cfg_stable_ms[MS_W-1:0];

  // one detector and debouncer per line, each with its own load strobe
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi = gi + 1)
    begin : g_line
      assign cfg_load[gi] = cfg_we && (cfg_line == LINE_W'(gi));
      assign sample_hit[gi] = sample_valid && (sample_line == LINE_W'(gi));

      idp_line u_line
      (
        .clock(clock),
        .rstn(rstn),
        .cfg_load(cfg_load[gi]),
        .cfg_fall(cfg_fall),
        .cfg_rise(cfg_rise),
        .cfg_stable_ms(stable_clamped),
        .sample_valid(sample_hit[gi]),
        .sample_level(sample_level),
        .ms_tick(ms_tick),
        .detected(detected[gi]),
        .state(debounced[gi])
      );
    end
  endgenerate

  // driven lines report the written value, not the pin level;
  // bit i of the mask steers line i
  assign view_word = (out_en_mask & out_data) | (~out_en_mask & debounced);

  // the whole word is taken on every read, whatever the view
  assign view_bit = view_word[read_line];
  assign next_read_data = (read_view == VIEW_WHOLE) ? view_word :
                          {{(LINES-1){1'b0}}, view_bit};

  // read answer, one cycle after the request
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      read_valid <= 1'b0;
      read_data <= '0;
      snapshot <= '0;
    end
    else
    begin
      read_valid <= read_req;
      if (read_req)
      begin
        read_data <= next_read_data;
        snapshot <= view_word;
      end
    end
  end

  // live status, registered so every output leaves a flip-flop
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      line_state <= '0;
      detect_state <= '0;
    end
    else
    begin
      line_state <= debounced;
      detect_state <= detected;
    end
  end

endmodule

// *** verilog/idp_pkg.sv ***
// shared constants and types for the industrial input debounce port
package idp_pkg;

  // port geometry
  localparam int LINES = 16;
  localparam int LINE_W = 4;
  localparam int LEVEL_W = 12;
  localparam int MS_W = 9;
  localparam int REQ_MS_W = 16;
  localparam int TICK_W = 16;

  // debounce interval limit in milliseconds
  localparam logic [MS_W-1:0] STABLE_MAX_MS = 9'h147;

  // clock rate and the millisecond tick derived from it
  localparam int CLOCK_HZ = 50000000;
  localparam int MS_PER_SEC = 1000;
  localparam int MS_CYCLES = CLOCK_HZ / MS_PER_SEC;

  // per-line configuration after reset
  localparam logic [LEVEL_W-1:0] FALL_RST = 12'h000;
  localparam logic [LEVEL_W-1:0] RISE_RST = 12'hfff;
  localparam logic [MS_W-1:0] STABLE_RST = 9'h000;

  // read view select
  localparam logic VIEW_WHOLE = 1'b0;
  localparam logic VIEW_LINE = 1'b1;

  typedef logic [LEVEL_W-1:0] idp_level_t;
  typedef logic [MS_W-1:0] idp_ms_t;
  typedef logic [LINES-1:0] idp_word_t;

endpackage

// *** verilog/idp_line.sv ***
// one input line: hysteresis detector, per-line settings and debouncer
`timescale 1ns/1ps
module idp_line
  import idp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // settings load
  input wire logic cfg_load,
  input wire idp_pkg::idp_level_t cfg_fall,
  input wire idp_pkg::idp_level_t cfg_rise,
  input wire idp_pkg::idp_ms_t cfg_stable_ms,
  // level samples and timebase
  input wire logic sample_valid,
  input wire idp_pkg::idp_level_t sample_level,
  input wire logic ms_tick,
  // results
  output logic detected,
  output logic state
);

  idp_level_t fall_threshold;
  idp_level_t rise_threshold;
  idp_ms_t stable_time_ms;
  idp_ms_t cnt;

  wire go_high;
  wire go_low;
  wire next_detected;
  wire changed;
  wire pending;
  wire bypass;
  wire [MS_W:0] cnt_inc;
  wire done;
  wire next_state;
  wire [MS_W-1:0] next_cnt;

  // settings live here so each line is reprogrammed alone
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fall_threshold <= FALL_RST;
      rise_threshold <= RISE_RST;
      stable_time_ms <= STABLE_RST;
    end
    else if (cfg_load)
    begin
      fall_threshold <= cfg_fall;
      rise_threshold <= cfg_rise;
      stable_time_ms <= cfg_stable_ms;
    end
  end

  // hysteresis: strict compares, in-between keeps the old level
  assign go_high = sample_level > rise_threshold;
  assign go_low = sample_level < fall_threshold;
  assign next_detected = !sample_valid ? detected :
                         go_high ? 1'b1 :
                         go_low ? 1'b0 :
                         detected;

  // debouncer: counter restarts on any detected change
  assign changed = next_detected != detected;
  assign pending = detected != state;
  assign bypass = stable_time_ms == STABLE_RST;
  assign cnt_inc = {1'b0, cnt} + {{MS_W{1'b0}}, 1'b1};
  assign done = pending && ms_tick && !changed && (cnt_inc >= {1'b0, stable_time_ms});
  assign next_state = (bypass || done) ? detected : state;
  assign next_cnt = (changed || !pending || done) ? '0 :
                    ms_tick ? cnt_inc[MS_W-1:0] :
                    cnt;

  // detector and debouncer state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      detected <= 1'b0;
      state <= 1'b0;
      cnt <= '0;
    end
    else
    begin
      detected <= next_detected;
      state <= next_state;
      cnt <= next_cnt;
    end
  end

endmodule

// *** sim/idp_props.sv ***
// checker on the port's read path and status outputs
`timescale 1ns/1ps
module idp_props
  import idp_pkg::*;
(
  // watched ports
  input wire logic clock,
  input wire logic rstn,
  input wire logic sample_valid,
  input wire logic read_req,
  input wire logic read_view,
  input wire logic [idp_pkg::LINE_W-1:0] read_line,
  input wire idp_pkg::idp_word_t out_en_mask,
  input wire idp_pkg::idp_word_t out_data,
  input wire logic read_valid,
  input wire logic [idp_pkg::LINES-1:0] read_data,
  input wire idp_pkg::idp_word_t line_state,
  input wire idp_pkg::idp_word_t detect_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // host view: driven lines show the written value; mask taken at the request edge,
  // line_state already carries the debounced value seen at that edge
  sequence s_ask;
    read_req ##1 read_valid;
  endsequence
  read_ans_a: assert property (read_req |-> s_ask) else $error("read not answered");
  no_spur_a: assert property (!read_req |=> !read_valid) else $error("answer without read");
  word_view_a: assert property (read_req && !read_view |=>
    read_data == (($past(out_en_mask) & $past(out_data)) | (~$past(out_en_mask) & line_state)))
    else $error("whole word wrong");
  line_bit_a: assert property (read_req && read_view |=> read_data == {15'h0,
    ($past(out_en_mask[read_line]) ? $past(out_data[read_line]) : line_state[$past(read_line)])})
    else $error("line value wrong");
  data_hold_a: assert property (!read_req |=> $stable(read_data)) else $error("read data moved");
  det_hold_a: assert property (!sample_valid |=> ##1 $stable(detect_state)) else $error("detect moved");
  det_src_a: assert property ($changed(detect_state) |-> $past(sample_valid, 2))
    else $error("detect changed unsampled");
  state_src_a: assert property (((line_state ^ $past(line_state)) & (line_state ^ $past(detect_state))) == 16'h0)
    else $error("state not from detector");
endmodule

// *** sim/idp_field.sv ***
// field model: a converter scan strobing one line every other cycle
`timescale 1ns/1ps
module idp_field
  import idp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // converter strobe toward the port
  output logic sample_valid,
  output logic [idp_pkg::LINE_W-1:0] sample_line,
  output idp_pkg::idp_level_t sample_level
);
  idp_level_t level [LINES] = '{default: 12'h200};
  logic [4:0] scan;
  // scan step counter
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      scan <= 5'h0;
    else
      scan <= scan + 5'h1;
  end
  // between strobes the code is inverted so a stale value is never trusted
  assign sample_valid = rstn & scan[0];
  assign sample_line = scan[4:1];
  assign sample_level = scan[0] ? level[scan[4:1]] : ~level[scan[4:1]];
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the sixteen-line input port
`timescale 1ns/1ps
module testbench;
  import idp_pkg::*;
  localparam int TK = 4;
  logic clock = 1'b0, rstn = 1'b0, cfg_we = 1'b0, read_req = 1'b0, read_view = 1'b0;
  logic [3:0] cfg_line = 4'h0, read_line = 4'h0, sample_line;
  idp_level_t cfg_fall = 12'h0, cfg_rise = 12'h0, sample_level;
  logic [15:0] cfg_stable_ms = 16'h0, read_data;
  idp_word_t out_en_mask = 16'h0, out_data = 16'h0, m_det, line_state, detect_state;
  logic sample_valid, read_valid;
  int bad_count = 0, comparisons = 0, cycles = 0, seed = 32'h1985;
  int fl [16] = '{default: 0};
  int rs [16] = '{default: 4095};
  idp_level_t lv [5] = '{12'h200, 12'h400, 12'h800, 12'hc00, 12'he00};
  always #10 clock = ~clock;
  idp_field i_field (.clock, .rstn, .sample_valid, .sample_line, .sample_level);
  idp_port #(.TICK_CYCLES(TK)) i_dut (.clock, .rstn, .cfg_we, .cfg_line, .cfg_fall, .cfg_rise, .cfg_stable_ms,
    .sample_valid, .sample_line, .sample_level, .out_en_mask, .out_data, .read_req, .read_view, .read_line,
    .read_valid, .read_data, .line_state, .detect_state);
  // bench detector; strict compares so a code equal to a threshold holds
  always @(posedge clock or negedge rstn)
    if (!rstn)
      m_det <= 16'h0;
    else if (sample_valid && sample_level > rs[sample_line])
      m_det[sample_line] <= 1'b1;
    else if (sample_valid && sample_level < fl[sample_line])
      m_det[sample_line] <= 1'b0;
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 10000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cfg(input int ln, st);
    @(posedge clock);
    cfg_we <= 1'b1;
    cfg_line <= ln[3:0];
    cfg_fall <= 12'h400;
    cfg_rise <= 12'hc00;
    cfg_stable_ms <= st[15:0];
    @(posedge clock);
    cfg_we <= 1'b0;
    fl[ln] = 'h400;
    rs[ln] = 'hc00;
  endtask
  task automatic rd(input logic v, input int ln, output logic [15:0] d);
    @(posedge clock);
    read_req <= 1'b1;
    read_view <= v;
    read_line <= ln[3:0];
    @(posedge clock);
    read_req <= 1'b0;
    #1;
    chk("read_valid", {15'h0, read_valid}, 16'h1);
    d = read_data;
  endtask
  // settle low, step high, then bracket the acceptance moment
  task automatic deb(input int ln, n);
    int t;
    t = 0;
    i_field.level[ln] <= 12'h100;
    repeat (n * TK + 80) @(posedge clock);
    i_field.level[ln] <= 12'hf00;
    while (detect_state[ln] !== 1'b1 && t < 100)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    repeat ((n - 1) * TK - 2) @(posedge clock);
    #1;
    chk("early", {15'h0, line_state[ln]}, 16'h0);
    repeat (TK + 4) @(posedge clock);
    #1;
    chk("late", {15'h0, line_state[ln]}, 16'h1);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    logic [15:0] d;
    int i;
    int k;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(1'b0, 0, d);
    chk("reset word", d, 16'h0);
    // inputs first with every drive enable clear; line 2 asks past the limit
    for (i = 0; i < 16; i++)
      cfg(i, i == 5 ? 3 : (i == 2 ? 'hffff : 0));
    $display("test config done");
    repeat (8)
    begin
      for (i = 0; i < 16; i++)
        i_field.level[i] <= lv[$unsigned($random(seed)) % 5];
      repeat (80) @(posedge clock);
      #1;
      chk("detect", detect_state, m_det);
      chk("state", line_state & 16'hfffb, m_det & 16'hfffb);
    end
    $display("test levels done");
    deb(5, 3);
    deb(2, 327);
    $display("test debounce done");
    for (k = 0; k < 4; k++)
    begin
      @(posedge clock);
      out_en_mask <= 16'($random(seed));
      out_data <= 16'($random(seed));
      rd(1'b0, 0, d);
      chk("whole", d, (out_en_mask & out_data) | (~out_en_mask & m_det));
      for (i = 0; i < 16; i++)
      begin
        rd(1'b1, i, d);
        chk("line", d, {15'h0, out_en_mask[i] ? out_data[i] : m_det[i]});
      end
    end
    $display("test readback done");
    test_done();
  end
endmodule
bind idp_port idp_props i_props (.clock, .rstn, .sample_valid, .read_req, .read_view, .read_line, .out_en_mask,
  .out_data, .read_valid, .read_data, .line_state, .detect_state);
